// ===== gpio_pad_param_and_keyed_mux_bench.sv
// Self-checking bench for the pad parameter and keyed function block.
`timescale 1ns/1ns
module gpio_pad_param_and_keyed_mux_bench;
  logic clk, rst, ce, wr, rd;
  logic [31:0] addr, wdata, rdata;
  logic [2:0][7:0] pin_in, pin_out, pin_oe, pullup_en, drive_high;
  logic [2:0][31:0] pfs;
  logic analog, i2c, spi;
  logic [1:0] v;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ----------------------------------------------------------------------
  // Clock, timeout and design
  // ----------------------------------------------------------------------
  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cuts a hang short after a generous cycle budget.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  gpk_top i_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .drive_high(drive_high), .port_function_select(pfs),
    .analog_input_select(analog), .serial_if_i2c(i2c),
    .serial_if_spi(spi));

  // ----------------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One write cycle; the strobe stays up for a following write.
  task wr_reg(input logic [31:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // Drops both strobes and lets cycles pass.
  task idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  // One read cycle; the answer is sampled in the following cycle.
  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clk);
  endtask

  // Key, value, key as three back-to-back writes.
  task key_seq(input logic [15:0] k1, input logic [7:0] d,
    input logic [15:0] k2);
    wr_reg(gpk_pkg::ADDR_P0_KEY_FIRST, {16'h0000, k1});
    wr_reg(gpk_pkg::ADDR_P0_FUNC_SEL, {24'h00_0000, d});
    wr_reg(gpk_pkg::ADDR_P0_KEY_SECOND, {16'h0000, k2});
    idle(2);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task finish_test();
    $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  // Reset, pad parameters, lock, keyed function updates.
  initial begin
    rst <= 1'b1;
    ce <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 32'h0000_0000;
    wdata <= 32'h0000_0000;
    pin_in <= {8'h81, 8'h3c, 8'h5a};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({8'h00, pullup_en}, 32'h00ff_ffff);
    chk({8'h00, drive_high}, 32'h0000_0000);
    chk({29'h0000_0000, analog, i2c, spi}, 32'h0000_0001);
    chk(pfs[0], gpk_pkg::FUNC_RESET);
    for (int p = 0; p < 3; p++) begin
      rd_chk(gpk_pkg::ADDR_PAD0 + 32'(p * 16), 32'h0000_0000);
    end
    rd_chk(gpk_pkg::ADDR_P0_FUNC_SEL, 32'h0000_0000);
    rd_chk(gpk_pkg::ADDR_P0_KEY_FIRST, 32'h0000_0000);
    rd_chk(gpk_pkg::ADDR_P0_KEY_SECOND, 32'h0000_0000);
    rd_chk(32'hffff_0500, 32'h0000_0000);
    $display("Test reset values done");

    // Pad settings apply only after the data register write.
    for (int p = 0; p < 3; p++) begin
      wr_reg(gpk_pkg::ADDR_PAD0 + 32'(p * 16), 32'h0000_a5ff);
      idle(2);
      chk({24'h00_0000, pullup_en[p]}, 32'h0000_00ff);
      rd_chk(gpk_pkg::ADDR_PAD0 + 32'(p * 16), 32'h0000_a5ff);
      wr_reg(gpk_pkg::ADDR_DATA0 + 32'(p * 16), 32'h0000_0000);
      idle(2);
      chk({24'h00_0000, drive_high[p]}, 32'h0000_00a5);
      chk({24'h00_0000, pullup_en[p]}, (p == 0) ? 32'h4 : 32'h0);
    end
    $display("Test pad parameters done");

    // A low clock enable freezes the registers against a write.
    ce <= 1'b0;
    wr_reg(gpk_pkg::ADDR_PAD2, 32'h0000_00ff);
    idle(2);
    ce <= 1'b1;
    rd_chk(gpk_pkg::ADDR_PAD2, 32'h0000_a5ff);
    $display("Test clock enable done");

    // A locked pin keeps its direction and output through writes.
    wr_reg(gpk_pkg::ADDR_DATA1, 32'h0101_0000);
    wr_reg(gpk_pkg::ADDR_PAD1, 32'h0003_0000);
    wr_reg(gpk_pkg::ADDR_DATA1, 32'h0000_0000);
    wr_reg(gpk_pkg::ADDR_CLR1, 32'h00ff_0000);
    wr_reg(gpk_pkg::ADDR_FUNC1, 32'hffff_ffff);
    idle(2);
    rd_chk(gpk_pkg::ADDR_DATA1, 32'h0101_3c3c);
    chk({16'h0000, pin_oe[1], pin_out[1]}, 32'h0000_0101);
    rd_chk(gpk_pkg::ADDR_FUNC1, 32'hffff_ffcc);
    chk(pfs[1], 32'hffff_ffcc);
    $display("Test pin lock done");

    // Every routing code through the full key sequence.
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      key_seq(gpk_pkg::KEY_FIRST_VALUE, {6'h00, v},
        gpk_pkg::KEY_SECOND_VALUE);
      rd_chk(gpk_pkg::ADDR_P0_FUNC_SEL, {30'h0000_0000, v});
      chk({29'h0000_0000, analog, i2c, spi},
        {29'h0000_0000, v[0], v[1] & ~v[0], ~v[1] & ~v[0]});
    end
    $display("Test keyed routing done");

    // Broken sequences leave the value 3 in place.
    key_seq(16'h0006, 8'h00, gpk_pkg::KEY_SECOND_VALUE);
    key_seq(gpk_pkg::KEY_FIRST_VALUE, 8'h00, 16'h0012);
    wr_reg(gpk_pkg::ADDR_P0_KEY_FIRST, 32'h0000_0007);
    rd_chk(gpk_pkg::ADDR_P0_FUNC_SEL, 32'h0000_0003);
    wr_reg(gpk_pkg::ADDR_P0_FUNC_SEL, 32'h0000_0000);
    wr_reg(gpk_pkg::ADDR_P0_KEY_SECOND, 32'h0000_0013);
    // An unrelated write between key and value breaks the sequence.
    wr_reg(gpk_pkg::ADDR_P0_KEY_FIRST, 32'h0000_0007);
    wr_reg(32'hffff_0500, 32'h0000_0000);
    wr_reg(gpk_pkg::ADDR_P0_FUNC_SEL, 32'h0000_0000);
    wr_reg(gpk_pkg::ADDR_P0_KEY_SECOND, 32'h0000_0013);
    idle(2);
    rd_chk(gpk_pkg::ADDR_P0_FUNC_SEL, 32'h0000_0003);
    chk({29'h0000_0000, analog, i2c, spi}, 32'h0000_0004);
    $display("Test broken key sequences done");
    finish_test();
  end
endmodule

// ===== gpk_checker.sv
// Checker with the port-level assertions of the pad and keyed function block.
`timescale 1ns/1ns
module gpk_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [2:0][7:0] pullup_en,
  input wire logic [2:0][7:0] drive_high,
  input wire logic analog_input_select,
  input wire logic serial_if_i2c,
  input wire logic serial_if_spi
);
  // ----------------------------------------------------------------------
  // Assertions on the register bus and the pad outputs
  // ----------------------------------------------------------------------
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Read data is zero in any cycle that follows an enabled cycle without a read.
  a_rdata_idle_zero:
    assert property ($past(ce) && !$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  // The port 0 bit 2 pull-up can never be switched off.
  a_port0_pull_keep:
    assert property (pullup_en[0][2] == 1'b1)
    else $error("port 0 bit 2 pull-up turned off");
  // Exactly one of analog, I2C and SPI routing is active.
  a_mode_one_hot:
    assert property ($onehot({analog_input_select, serial_if_i2c,
      serial_if_spi}))
    else $error("pin routing outputs not one-hot");
  // A routing change is only the result of a full key sequence.
  a_func_keyed_only:
    assert property ($changed({analog_input_select, serial_if_i2c}) &&
      !$past(rst) |->
      $past(wr && addr == gpk_pkg::ADDR_P0_KEY_SECOND &&
        wdata[15:0] == gpk_pkg::KEY_SECOND_VALUE, 2) &&
      $past(wr && addr == gpk_pkg::ADDR_P0_FUNC_SEL, 3) &&
      $past(wr && addr == gpk_pkg::ADDR_P0_KEY_FIRST &&
        wdata[15:0] == gpk_pkg::KEY_FIRST_VALUE, 4))
    else $error("routing changed without the key sequence");
  // Port 0 drive strength follows a port 0 data register write two cycles back.
  a_drive_capture:
    assert property ($changed(drive_high[0]) && !$past(rst) |->
      $past(wr && addr == gpk_pkg::ADDR_DATA0, 2))
    else $error("drive strength changed without a data write");
  // Port 2 pull-up enables follow a port 2 data register write two cycles back.
  a_pull_capture:
    assert property ($changed(pullup_en[2]) && !$past(rst) |->
      $past(wr && addr == gpk_pkg::ADDR_DATA2, 2))
    else $error("pull-up changed without a data write");
  // The key registers read as zero.
  a_key_read_zero:
    assert property (rd && (addr == gpk_pkg::ADDR_P0_KEY_FIRST ||
      addr == gpk_pkg::ADDR_P0_KEY_SECOND) |=> rdata == 32'h0000_0000)
    else $error("key register read not zero");
  // The function register read agrees with the routing outputs.
  a_func_read_match:
    assert property (rd && addr == gpk_pkg::ADDR_P0_FUNC_SEL |=>
      rdata[31:8] == 24'h00_0000 && rdata[0] == analog_input_select &&
      (rdata[0] || rdata[1] == serial_if_i2c))
    else $error("function register read disagrees with routing");

  // Main scenarios reached by the bench.
  c_key_done: cover property (wr && addr == gpk_pkg::ADDR_P0_KEY_SECOND);
  c_i2c_on: cover property ($rose(serial_if_i2c));
  c_analog_on: cover property ($rose(analog_input_select));
  c_drive_set: cover property ($changed(drive_high[0]));
endmodule

bind gpk_top gpk_checker i_chk (
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .pullup_en(pullup_en),
  .drive_high(drive_high),
  .analog_input_select(analog_input_select),
  .serial_if_i2c(serial_if_i2c),
  .serial_if_spi(serial_if_spi)
);

// ===== gpk_pkg.sv
// Package with the register map, field layout and types of the pad block.
// Function
// - Port 0 bit 2 pull-up always on
// - Lock bit blocks function and data writes
// - Drive bit selects 2 mA or 4 mA
// - Pull-up disable bit turns pull-up off
// - Bit 1 picks SPI or I2C routing
// - Serial pick works only when analog clear
// - Bit 0 makes pins 0-3 analog inputs
package gpk_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_P0_KEY_FIRST = 32'hffff_0464;
  localparam logic [31:0] ADDR_P0_FUNC_SEL = 32'hffff_0468;
  localparam logic [31:0] ADDR_P0_KEY_SECOND = 32'hffff_046c;
  localparam logic [31:0] ADDR_FUNC0 = 32'hffff_0d00;
  localparam logic [31:0] ADDR_FUNC1 = 32'hffff_0d04;
  localparam logic [31:0] ADDR_FUNC2 = 32'hffff_0d08;
  localparam logic [31:0] ADDR_DATA0 = 32'hffff_0d20;
  localparam logic [31:0] ADDR_SET0 = 32'hffff_0d24;
  localparam logic [31:0] ADDR_CLR0 = 32'hffff_0d28;
  localparam logic [31:0] ADDR_PAD0 = 32'hffff_0d2c;
  localparam logic [31:0] ADDR_DATA1 = 32'hffff_0d30;
  localparam logic [31:0] ADDR_SET1 = 32'hffff_0d34;
  localparam logic [31:0] ADDR_CLR1 = 32'hffff_0d38;
  localparam logic [31:0] ADDR_PAD1 = 32'hffff_0d3c;
  localparam logic [31:0] ADDR_DATA2 = 32'hffff_0d40;
  localparam logic [31:0] ADDR_SET2 = 32'hffff_0d44;
  localparam logic [31:0] ADDR_CLR2 = 32'hffff_0d48;
  localparam logic [31:0] ADDR_PAD2 = 32'hffff_0d4c;

  // ----------------------------------------------------------------------
  // Key values and field positions
  // ----------------------------------------------------------------------
  localparam logic [15:0] KEY_FIRST_VALUE = 16'h0007;
  localparam logic [15:0] KEY_SECOND_VALUE = 16'h0013;
  localparam int LOCK_LSB = 16;
  localparam int DRIVE_LSB = 8;
  localparam int PULLUP_DIS_LSB = 0;
  localparam int DIR_LSB = 24;
  localparam int OUT_LSB = 16;
  localparam int RESET_STATE_LSB = 8;
  localparam int ANALOG_SEL_BIT = 0;
  localparam int SERIAL_SEL_BIT = 1;

  // ----------------------------------------------------------------------
  // Reset values and constant masks
  // ----------------------------------------------------------------------
  localparam logic [31:0] FUNC_RESET = 32'h0000_0000;
  localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] P0_PULLUP_KEEP = 8'h04;
  localparam logic [1:0] SETTLE_COUNT = 2'h3;

  // Per-port pad parameters as held in one register.
  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] drive;
    logic [7:0] pullup_dis;
  } gpk_pad_s;

  // Key sequence states, one-hot.
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_ARMED = 3'b010,
    KEY_HELD = 3'b100
  } gpk_key_e;

endpackage

// ===== gpk_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ns
module gpk_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift chain; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit changes only once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= (q & (s2 ^ s3)) | (s2 & ~(s2 ^ s3));
    end
  end

endmodule

// ===== gpk_top.sv
// Pad parameter, port register and keyed port 0 function block.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module gpk_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [2:0][7:0] pin_in,
  output logic [2:0][7:0] pin_out,
  output logic [2:0][7:0] pin_oe,
  output logic [2:0][7:0] pullup_en,
  output logic [2:0][7:0] drive_high,
  output logic [2:0][31:0] port_function_select,
  output logic analog_input_select,
  output logic serial_if_i2c,
  output logic serial_if_spi
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Lock, drive and pull-up fields, as written and as applied to the pads.
  gpk_pkg::gpk_pad_s pad_param_register [3];
  gpk_pkg::gpk_pad_s pad_applied [3];
  logic [31:0] func_reg [3];
  logic [7:0] dir_reg [3];
  logic [7:0] out_reg [3];
  logic [7:0] reset_state [3];
  logic [7:0] port0_function_select;
  logic [7:0] func_pending;
  gpk_pkg::gpk_key_e key_state;
  logic [2:0][7:0] pin_sync;
  logic [1:0] settle_cnt;
  logic settle_done;
  logic captured;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [2:0] hit_pad;
  logic [2:0] hit_func;
  logic [2:0] hit_data;
  logic [2:0] hit_set;
  logic [2:0] hit_clr;
  logic hit_key1;
  logic hit_key2;
  logic hit_con1;
  logic key1_ok;
  logic key2_ok;

  // Address compares for each port register.
  // Reserved and unmapped addresses hit nothing, so they read as zero.
  always_comb begin
    hit_pad[0] = addr == gpk_pkg::ADDR_PAD0;
    hit_pad[1] = addr == gpk_pkg::ADDR_PAD1;
    hit_pad[2] = addr == gpk_pkg::ADDR_PAD2;
    hit_func[0] = addr == gpk_pkg::ADDR_FUNC0;
    hit_func[1] = addr == gpk_pkg::ADDR_FUNC1;
    hit_func[2] = addr == gpk_pkg::ADDR_FUNC2;
    hit_data[0] = addr == gpk_pkg::ADDR_DATA0;
    hit_data[1] = addr == gpk_pkg::ADDR_DATA1;
    hit_data[2] = addr == gpk_pkg::ADDR_DATA2;
    hit_set[0] = addr == gpk_pkg::ADDR_SET0;
    hit_set[1] = addr == gpk_pkg::ADDR_SET1;
    hit_set[2] = addr == gpk_pkg::ADDR_SET2;
    hit_clr[0] = addr == gpk_pkg::ADDR_CLR0;
    hit_clr[1] = addr == gpk_pkg::ADDR_CLR1;
    hit_clr[2] = addr == gpk_pkg::ADDR_CLR2;
    hit_key1 = addr == gpk_pkg::ADDR_P0_KEY_FIRST;
    hit_key2 = addr == gpk_pkg::ADDR_P0_KEY_SECOND;
    hit_con1 = addr == gpk_pkg::ADDR_P0_FUNC_SEL;
  end

  // Key writes count only with the exact key value.
  assign key1_ok = wr && hit_key1 &&
                   (wdata[15:0] == gpk_pkg::KEY_FIRST_VALUE);
  assign key2_ok = wr && hit_key2 &&
                   (wdata[15:0] == gpk_pkg::KEY_SECOND_VALUE);

  // Spread each pin lock over its two-bit function field.
  // Pin i owns bits 4i+1:4i; the two bits above each field are reserved.
  function automatic logic [31:0] func_mask(input logic [7:0] lock);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      m[4*i] = lock[i];
      m[4*i+1] = lock[i];
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------
  // All 24 pins share one synchroniser; port p sits in byte p.
  gpk_sync #(
    .W(24)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(pin_in),
    .q(pin_sync)
  );

  // Catch the settled pin levels once after reset as the reset state.
  // The filter shows the pin level only one cycle after the count ends,
  // so the capture waits for one extra settle step.
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_cnt <= 2'h0;
      settle_done <= 1'b0;
      captured <= 1'b0;
      for (int p = 0; p < 3; p++) begin
        reset_state[p] <= gpk_pkg::BYTE_RESET;
      end
    end else if (ce && !captured) begin
      if (settle_done) begin
        captured <= 1'b1;
        for (int p = 0; p < 3; p++) begin
          reset_state[p] <= pin_sync[p];
        end
      end else if (settle_cnt == gpk_pkg::SETTLE_COUNT) begin
        settle_done <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pad parameter registers
  // ----------------------------------------------------------------------
  // Plain read/write storage of lock, drive and pull-up fields.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 3; p++) begin
        pad_param_register[p] <= '0;
      end
    end else if (ce && wr) begin
      for (int p = 0; p < 3; p++) begin
        if (hit_pad[p]) begin
          pad_param_register[p] <= wdata[23:0];
        end
      end
    end
  end

  // New pad settings reach the pads when the data register is written.
  // Until then the pads keep the settings of the last data write.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 3; p++) begin
        pad_applied[p] <= '0;
      end
    end else if (ce && wr) begin
      for (int p = 0; p < 3; p++) begin
        if (hit_data[p]) begin
          pad_applied[p] <= pad_param_register[p];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Function select registers
  // ----------------------------------------------------------------------
  // Locked pins keep their function field.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 3; p++) begin
        func_reg[p] <= gpk_pkg::FUNC_RESET;
      end
    end else if (ce && wr) begin
      for (int p = 0; p < 3; p++) begin
        if (hit_func[p]) begin
          func_reg[p] <=
            (func_reg[p] & func_mask(pad_param_register[p].lock)) |
            (wdata & ~func_mask(pad_param_register[p].lock));
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data and direction registers
  // ----------------------------------------------------------------------
  // Data, set and clear writes all skip locked pins.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 3; p++) begin
        dir_reg[p] <= gpk_pkg::BYTE_RESET;
        out_reg[p] <= gpk_pkg::BYTE_RESET;
      end
    end else if (ce && wr) begin
      for (int p = 0; p < 3; p++) begin
        if (hit_data[p]) begin
          dir_reg[p] <= (dir_reg[p] & pad_param_register[p].lock) |
            (wdata[gpk_pkg::DIR_LSB +: 8] &
             ~pad_param_register[p].lock);
          out_reg[p] <= (out_reg[p] & pad_param_register[p].lock) |
            (wdata[gpk_pkg::OUT_LSB +: 8] &
             ~pad_param_register[p].lock);
        end else if (hit_set[p]) begin
          out_reg[p] <= out_reg[p] | (wdata[gpk_pkg::OUT_LSB +: 8] &
            ~pad_param_register[p].lock);
        end else if (hit_clr[p]) begin
          out_reg[p] <= out_reg[p] & ~(wdata[gpk_pkg::OUT_LSB +: 8] &
            ~pad_param_register[p].lock);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Port 0 function key sequence
  // ----------------------------------------------------------------------
  // Any access moves the sequence; only key, value, key commits.
  always_ff @(posedge clk) begin
    if (rst) begin
      key_state <= gpk_pkg::KEY_IDLE;
      func_pending <= gpk_pkg::FUNC_SEL_RESET;
    end else if (ce && (wr || rd)) begin
      unique case (key_state)
        gpk_pkg::KEY_IDLE: begin
          if (key1_ok) begin
            key_state <= gpk_pkg::KEY_ARMED;
          end
        end
        gpk_pkg::KEY_ARMED: begin
          // A read or any other write here breaks the sequence; a valid first key write keeps it armed.
          if (wr && hit_con1) begin
            key_state <= gpk_pkg::KEY_HELD;
            func_pending <= wdata[7:0];
          end else if (key1_ok) begin
            key_state <= gpk_pkg::KEY_ARMED;
          end else begin
            key_state <= gpk_pkg::KEY_IDLE;
          end
        end
        gpk_pkg::KEY_HELD: begin
          // The commit itself is taken in the register process below.
          if (key1_ok) begin
            key_state <= gpk_pkg::KEY_ARMED;
          end else begin
            key_state <= gpk_pkg::KEY_IDLE;
          end
        end
        default: begin
          key_state <= gpk_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // The register changes only on the closing key write.
  // A wrong second key drops the pending value with no trace.
  always_ff @(posedge clk) begin
    if (rst) begin
      port0_function_select <= gpk_pkg::FUNC_SEL_RESET;
    end else if (ce && key2_ok && key_state == gpk_pkg::KEY_HELD) begin
      port0_function_select <= func_pending;
    end
  end

  // ----------------------------------------------------------------------
  // Pad and routing outputs
  // ----------------------------------------------------------------------
  // Drive enables, levels, pulls and drive strength, all registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      pullup_en <= {3{8'hff}};
      drive_high <= '0;
      port_function_select <= '0;
    end else if (ce) begin
      for (int p = 0; p < 3; p++) begin
        pin_out[p] <= out_reg[p];
        pin_oe[p] <= dir_reg[p];
        pullup_en[p] <= ~pad_applied[p].pullup_dis;
        drive_high[p] <= pad_applied[p].drive;
        port_function_select[p] <= func_reg[p];
      end
      // Port 0 bit 2 keeps its pull-up whatever the disable bit holds.
      pullup_en[0] <= ~pad_applied[0].pullup_dis |
                      gpk_pkg::P0_PULLUP_KEEP;
    end
  end

  // Analog pick overrides the serial pick on port 0 pins 0 to 3.
  always_ff @(posedge clk) begin
    if (rst) begin
      analog_input_select <= 1'b0;
      serial_if_i2c <= 1'b0;
      serial_if_spi <= 1'b1;
    end else if (ce) begin
      analog_input_select <=
        port0_function_select[gpk_pkg::ANALOG_SEL_BIT];
      serial_if_i2c <=
        port0_function_select[gpk_pkg::SERIAL_SEL_BIT] &
        ~port0_function_select[gpk_pkg::ANALOG_SEL_BIT];
      serial_if_spi <=
        ~port0_function_select[gpk_pkg::SERIAL_SEL_BIT] &
        ~port0_function_select[gpk_pkg::ANALOG_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Read data stand one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        for (int p = 0; p < 3; p++) begin
          if (hit_pad[p]) begin
            rdata <= {8'h00, pad_param_register[p]};
          end
          if (hit_func[p]) begin
            rdata <= func_reg[p];
          end
          if (hit_data[p]) begin
            rdata <= {dir_reg[p], out_reg[p], reset_state[p], pin_sync[p]};
          end
        end
        // Key registers are write-only and fall through to zero.
        if (hit_con1) begin
          rdata <= {24'h00_0000, port0_function_select};
        end
      end
    end
  end

endmodule
